// ---- rsc_defines.vh ----
// Constants for the reset source capture block: register offsets,
// field positions, reset values and timing figures.
// Assumes a 50 MHz system clock and a Wishbone slave with byte addresses.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RSC_OFS_CAUSE 4'h0
`define RSC_OFS_IRQ_STATUS 4'h4
`define RSC_OFS_IRQ_MASK 4'h8
`define RSC_OFS_CONTROL 4'hC

// ****************************************
// Reset cause register fields
// ****************************************
`define RSC_PIN_RESET_BIT 0
`define RSC_POWER_ON_BIT 1
`define RSC_MISSING_CLOCK_BIT 2
`define RSC_WATCHDOG_CAUSE_FLAG 3
`define RSC_SOFTWARE_FORCE_BIT 4
`define RSC_COMPARATOR_RESET_BIT 5
`define RSC_CONVERT_START_RESET_BIT 6
`define RSC_CAUSE_W 7

// ****************************************
// Control register fields (read only)
// ****************************************
`define RSC_CTL_MCD_EN 0
`define RSC_CTL_SUPPLY_SEL 1
`define RSC_CTL_CMP_EN 2
`define RSC_CTL_CNV_EN 3
`define RSC_CTL_SYS_RESET 4
`define RSC_CTL_MON_PIN 5

// ****************************************
// Reset values
// ****************************************
`define RSC_FLAGS_RESET 7'h00
`define RSC_CAUSE_RESET 7'h02
`define RSC_IRQ_STATUS_RESET 7'h00
`define RSC_IRQ_MASK_RESET 7'h00
`define RSC_SUPPLY_SEL_RESET 1'h1

// ****************************************
// Timing
// ****************************************
`define RSC_CLK_PERIOD_NS 20
`define RSC_MCD_TIMEOUT_US 100
`define RSC_POR_DELAY_MS 100
`define RSC_PIN_EXIT_CYCLES 12
`define RSC_INT_HOLD_CYCLES 12

`endif

// ---- rsc_pin_partner.sv ----
// Model of the outside circuitry on the open-drain reset pin.
// Assumes a pull-up on the pin; the bench commands any outside pull-down.
`timescale 1ns/1ps
// ****
// Pin model
// ****
module rsc_pin_partner (
	input wire rstPinOut,
	input wire rstPinOeN,
	input wire pullLow,
	output wire rstPinIn
);
	// Pull-up wins only while no party pulls low, so a released pin never keeps an old level
	assign rstPinIn = ((!rstPinOeN && !rstPinOut) || pullLow) ? 1'b0 : 1'b1;
endmodule

// ---- rsc_reset_source_capture.v ----
// Reset source capture and system reset sequencer with a Wishbone register port.
// Assumes srst is the true power-on reset, wdtTimeout comes from logic on clk,
// and all other event inputs are asynchronous levels.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "rsc_defines.vh"

// Functional notes
// [RULE1] Software force write of one starts internal reset, pin untouched; zero ignored.
// [RULE2] Software force flag reads one only after a software forced reset.
// [RULE3] Watchdog flag reads one only after a watchdog timeout reset.
// [RULE4] Missing clock bit write enables or disables the missing clock detector.
// [RULE5] Missing clock flag reads one only after a missing clock reset.
// [RULE6] Power-on bit write selects supply monitor as source when monitor pin enabled.
// [RULE7] Power-on flag set by power-on or supply monitor reset only.
// [RULE8] Software treats other flags as indeterminate when power-on flag reads one.
// [RULE9] Pin reset bit write of one forces power-on reset, drives pin low.
// [RULE10] Pin reset flag reads one only after an external pin reset.
// [RULE11] Enabled detector resets after system clock absent 100 to 500 us.
// [RULE12] After supply recovers, hold reset and pin low for about 100 ms.
// [RULE13] Stay in reset twelve cycles after pin release; then set pin flag.
// [RULE14] Bit 7 reserved; bits 6 and 5 enable and flag convert/comparator resets.
// [RULE15] Each reset leaves exactly one flag set; enables return to defaults.
module rsc_reset_source_capture #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] POR_CYCLES = (`RSC_POR_DELAY_MS * 1000000) / `RSC_CLK_PERIOD_NS,
	parameter [CNT_W-1:0] MCD_CYCLES = (`RSC_MCD_TIMEOUT_US * 1000 + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS
) (
	input wire clk,
	input wire srst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire wdtTimeout,
	input wire watchedClkToggle,
	input wire supplyLow,
	input wire supplyMonitorEnablePin,
	input wire convertStartInputN,
	input wire comparatorOutN,
	input wire rstPinIn,
	output wire rstPinOut,
	output wire rstPinOeN,
	output wire sysReset,
	output wire irq
);

	// ****************************************
	// States and local constants
	// ****************************************
	localparam ST_RUN = 2'b00;
	localparam ST_HOLD = 2'b01;
	localparam ST_RELEASE = 2'b10;
	localparam [CNT_W-1:0] PIN_EXIT = `RSC_PIN_EXIT_CYCLES;
	localparam [CNT_W-1:0] INT_HOLD = `RSC_INT_HOLD_CYCLES;
	localparam [CNT_W-1:0] CNT_ONE = 1;

	// ****************************************
	// Registers
	// ****************************************
	reg [1:0] stateReg;
	reg [CNT_W-1:0] cntReg;
	reg [CNT_W-1:0] mcdCntReg;
	reg [`RSC_CAUSE_W-1:0] causeReg;
	reg [`RSC_CAUSE_W-1:0] flagsReg;
	reg [`RSC_CAUSE_W-1:0] irqStatusReg;
	reg [`RSC_CAUSE_W-1:0] irqMaskReg;
	reg mcdEnReg;
	reg supplySelReg;
	reg cmpEnReg;
	reg cnvEnReg;
	reg sysResetReg;
	reg rstPinOeNReg;
	reg rstPinOutReg;
	reg irqReg;
	reg ackReg;
	reg [31:0] datReg;
	reg toggleSeenReg;

	// ****************************************
	// Input synchronisers
	// ****************************************
	wire [5:0] syncOut;
	wire toggleSync;
	wire monPinSync;
	wire supplyLowSync;
	wire pinSync;
	wire cnvSync;
	wire cmpSync;

	rsc_sync2 #(
		.WIDTH(6)
	) uSync (
		.clk(clk),
		.srst(srst),
		.din({watchedClkToggle, supplyMonitorEnablePin, ~supplyLow, rstPinIn, convertStartInputN, comparatorOutN}),
		.dout(syncOut)
	);

	assign toggleSync = syncOut[5];
	assign monPinSync = syncOut[4];
	assign supplyLowSync = ~syncOut[3];
	assign pinSync = syncOut[2];
	assign cnvSync = syncOut[1];
	assign cmpSync = syncOut[0];

	// ****************************************
	// Bus decode
	// ****************************************
	wire wbReq = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	wire wbWrite = wbReq & wb_we_i & ackReg & wb_sel_i[0];
	wire causeWr = wbWrite & (wb_adr_i == `RSC_OFS_CAUSE);
	wire statusWr = wbWrite & (wb_adr_i == `RSC_OFS_IRQ_STATUS);
	wire maskWr = wbWrite & (wb_adr_i == `RSC_OFS_IRQ_MASK);
	wire swForce = causeWr & wb_dat_i[`RSC_SOFTWARE_FORCE_BIT]; // RULE1
	wire pinForce = causeWr & wb_dat_i[`RSC_PIN_RESET_BIT]; // RULE9

	// ****************************************
	// Reset sources
	// ****************************************
	wire pinLow = ~pinSync;
	wire supplyTrip = monPinSync & supplySelReg & supplyLowSync; // RULE6
	wire cnvTrip = cnvEnReg & ~cnvSync; // RULE14
	wire cmpTrip = cmpEnReg & ~cmpSync; // RULE14
	wire toggleEdge = toggleSync ^ toggleSeenReg;
	wire mcdTrip = mcdEnReg & (mcdCntReg >= MCD_CYCLES); // RULE11
	wire inRun = (stateReg == ST_RUN);

	// Level still holding the chip in reset for the latched cause
	reg srcActive;
	reg [CNT_W-1:0] holdLoad;
	always @* begin
		srcActive = 1'b0;
		holdLoad = INT_HOLD;
		if (causeReg[`RSC_POWER_ON_BIT]) begin
			srcActive = monPinSync & supplyLowSync; // RULE12
			holdLoad = POR_CYCLES;
		end else if (causeReg[`RSC_PIN_RESET_BIT]) begin
			srcActive = pinLow; // RULE13
			holdLoad = PIN_EXIT;
		end else if (causeReg[`RSC_COMPARATOR_RESET_BIT]) begin
			srcActive = ~cmpSync;
			holdLoad = PIN_EXIT;
		end else if (causeReg[`RSC_CONVERT_START_RESET_BIT]) begin
			srcActive = ~cnvSync;
			holdLoad = PIN_EXIT;
		end
	end

	// Entry decision in priority order; power class wins over all others
	reg enterReset;
	reg enterDrive;
	reg [`RSC_CAUSE_W-1:0] enterCause;
	reg [CNT_W-1:0] enterLoad;
	always @* begin
		enterReset = inRun;
		enterDrive = 1'b0;
		enterCause = `RSC_FLAGS_RESET;
		enterLoad = INT_HOLD;
		if (supplyTrip | pinForce) begin
			enterCause[`RSC_POWER_ON_BIT] = 1'b1; // RULE7
			enterDrive = 1'b1; // RULE9
			enterLoad = POR_CYCLES;
		end else if (pinLow) begin
			enterCause[`RSC_PIN_RESET_BIT] = 1'b1; // RULE10
			enterLoad = PIN_EXIT;
		end else if (mcdTrip) begin
			enterCause[`RSC_MISSING_CLOCK_BIT] = 1'b1; // RULE5
		end else if (wdtTimeout) begin
			enterCause[`RSC_WATCHDOG_CAUSE_FLAG] = 1'b1; // RULE3
		end else if (swForce) begin
			enterCause[`RSC_SOFTWARE_FORCE_BIT] = 1'b1; // RULE2
		end else if (cmpTrip) begin
			enterCause[`RSC_COMPARATOR_RESET_BIT] = 1'b1; // RULE14
			enterLoad = PIN_EXIT;
		end else if (cnvTrip) begin
			enterCause[`RSC_CONVERT_START_RESET_BIT] = 1'b1; // RULE14
			enterLoad = PIN_EXIT;
		end else begin
			enterReset = 1'b0;
		end
	end

	// ****************************************
	// Missing clock detector
	// ****************************************
	// Counts system cycles with no edge on the watched clock; disabled means cleared
	always @(posedge clk) begin
		if (srst) begin
			toggleSeenReg <= 1'b1;
			mcdCntReg <= {CNT_W{1'b0}};
		end else begin
			toggleSeenReg <= toggleSync;
			if (!mcdEnReg || toggleEdge) begin
				mcdCntReg <= {CNT_W{1'b0}}; // RULE4
			end else if (mcdCntReg < MCD_CYCLES) begin
				mcdCntReg <= mcdCntReg + CNT_ONE; // RULE11
			end
		end
	end

	// ****************************************
	// Reset sequencer
	// ****************************************
	reg exitReset;
	always @* begin
		exitReset = 1'b0;
		if (stateReg == ST_HOLD && !srcActive && cntReg <= CNT_ONE && rstPinOeNReg) begin
			exitReset = 1'b1;
		end else if (stateReg == ST_RELEASE && pinSync) begin
			exitReset = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			stateReg <= ST_HOLD;
			causeReg <= `RSC_CAUSE_RESET;
			cntReg <= POR_CYCLES;
			sysResetReg <= 1'b1;
			rstPinOeNReg <= 1'b0;
			rstPinOutReg <= 1'b0;
			flagsReg <= `RSC_FLAGS_RESET;
			mcdEnReg <= 1'b0;
			supplySelReg <= `RSC_SUPPLY_SEL_RESET;
			cmpEnReg <= 1'b0;
			cnvEnReg <= 1'b0;
		end else begin
			rstPinOutReg <= 1'b0;
			if (causeWr) begin
				mcdEnReg <= wb_dat_i[`RSC_MISSING_CLOCK_BIT]; // RULE4
				supplySelReg <= wb_dat_i[`RSC_POWER_ON_BIT]; // RULE6
				cmpEnReg <= wb_dat_i[`RSC_COMPARATOR_RESET_BIT]; // RULE14
				cnvEnReg <= wb_dat_i[`RSC_CONVERT_START_RESET_BIT]; // RULE14
			end
			case (stateReg)
				ST_RUN: begin
					if (enterReset) begin
						stateReg <= ST_HOLD;
						causeReg <= enterCause;
						cntReg <= enterLoad;
						sysResetReg <= 1'b1;
						rstPinOeNReg <= ~enterDrive; // RULE1
						// Enables return to defaults on every reset
						mcdEnReg <= 1'b0; // RULE15
						supplySelReg <= `RSC_SUPPLY_SEL_RESET;
						cmpEnReg <= 1'b0;
						cnvEnReg <= 1'b0;
					end
				end
				ST_HOLD: begin
					if (srcActive) begin
						cntReg <= holdLoad; // RULE12
					end else if (cntReg > CNT_ONE) begin
						cntReg <= cntReg - CNT_ONE; // RULE13
					end else if (!rstPinOeNReg) begin
						// Let the pin rise before leaving, so our own drive is not seen as a pin reset
						rstPinOeNReg <= 1'b1;
						stateReg <= ST_RELEASE;
					end
				end
				ST_RELEASE: stateReg <= ST_RELEASE;
				default: begin
					stateReg <= ST_HOLD;
					cntReg <= INT_HOLD;
				end
			endcase
			if (exitReset) begin
				stateReg <= ST_RUN;
				sysResetReg <= 1'b0;
				flagsReg <= causeReg; // RULE15
			end
		end
	end

	// ****************************************
	// Interrupt status and mask
	// ****************************************
	// A set in the same cycle as a write-one clear wins
	wire [`RSC_CAUSE_W-1:0] irqSet = exitReset ? causeReg : `RSC_IRQ_STATUS_RESET;
	wire [`RSC_CAUSE_W-1:0] irqClr = statusWr ? wb_dat_i[`RSC_CAUSE_W-1:0] : `RSC_IRQ_STATUS_RESET;

	always @(posedge clk) begin
		if (srst) begin
			irqStatusReg <= `RSC_IRQ_STATUS_RESET;
			irqMaskReg <= `RSC_IRQ_MASK_RESET;
			irqReg <= 1'b0;
		end else begin
			irqStatusReg <= (irqStatusReg & ~irqClr) | irqSet;
			if (maskWr) begin
				irqMaskReg <= wb_dat_i[`RSC_CAUSE_W-1:0];
			end
			irqReg <= |(irqStatusReg & irqMaskReg);
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// Every address answers, unmapped ones with zero, so a stray access never hangs
	reg [31:0] readMux;
	always @* begin
		readMux = 32'h0000_0000;
		case (wb_adr_i)
			`RSC_OFS_CAUSE: readMux = {25'h0000000, flagsReg}; // RULE14
			`RSC_OFS_IRQ_STATUS: readMux = {25'h0000000, irqStatusReg};
			`RSC_OFS_IRQ_MASK: readMux = {25'h0000000, irqMaskReg};
			`RSC_OFS_CONTROL: readMux = {26'h0000000, monPinSync, sysResetReg, cnvEnReg, cmpEnReg,
				supplySelReg, mcdEnReg};
			default: readMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			ackReg <= 1'b0;
			datReg <= 32'h0000_0000;
		end else begin
			ackReg <= wbReq & ~ackReg;
			if (wbReq & ~ackReg) begin
				datReg <= readMux;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o = ackReg;
	assign wb_dat_o = datReg;
	assign rstPinOut = rstPinOutReg;
	assign rstPinOeN = rstPinOeNReg;
	assign sysReset = sysResetReg;
	assign irq = irqReg;

endmodule

// ---- rsc_reset_source_capture_assertions.sv ----
// Checker on the ports of the reset source capture block.
// Assumes the watchdog input drops before the reset it caused ends.
`timescale 1ns/1ps
// ****
// Checker
// ****
module rsc_checker (
	input wire clk,
	input wire srst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire wdtTimeout,
	input wire rstPinIn,
	input wire rstPinOut,
	input wire rstPinOeN,
	input wire sysReset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence wdtEntry;
		!sysReset && wdtTimeout ##1 sysReset;
	endsequence
	sequence pinExit;
		$rose(rstPinIn) && $past(rstPinOeN) && sysReset;
	endsequence
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_wdt_entry: assert property (!sysReset && wdtTimeout |=> sysReset)
		else $error("watchdog did not start reset");
	chk_wdt_hold: assert property (wdtEntry |-> sysReset[*8] ##1 sysReset[*4])
		else $error("watchdog reset too short");
	chk_wdt_exit: assert property (wdtEntry |-> ##[12:40] !sysReset)
		else $error("watchdog reset too long");
	chk_pin_entry: assert property (!sysReset && !rstPinIn |-> ##[1:6] sysReset)
		else $error("pin low did not start reset");
	chk_pin_hold: assert property (pinExit |-> sysReset[*8] ##1 sysReset[*4])
		else $error("reset left too early after pin release");
	chk_drive_reset: assert property (!rstPinOeN |-> sysReset && !rstPinOut)
		else $error("pin driven outside reset");
	chk_por_hold: assert property ($fell(srst) |-> (sysReset && !rstPinOeN)[*8])
		else $error("power-on hold missing");
endmodule
bind rsc_reset_source_capture rsc_checker u_rsc_checker (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.wdtTimeout, .rstPinIn, .rstPinOut, .rstPinOeN, .sysReset);

// ---- rsc_reset_source_capture_test.sv ----
// Self-checking bench: random reset causes, cause flags, enables and interrupt.
// Assumes the pin model with pull-up and a 50 MHz clock.
`timescale 1ns/1ps
// ****
// Bench
// ****
module rsc_reset_source_capture_test;
	reg clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt = 1'b0, tog = 1'b0, togRun = 1'b1;
	reg supLow = 1'b0, supply_monitor_enable_pin = 1'b1, cnvN = 1'b1, cmpN = 1'b1, pullLow = 1'b0, drv = 1'b0;
	reg [3:0] adr = 4'h0;
	reg [31:0] wdat = 32'h0, seed = 32'h8C58;
	reg [7:0] q;
	wire [31:0] rdat;
	wire ack, pinIn, pinOut, pinOeN, sysRst, irq;
	integer fails = 0, compares = 0, k, i, n;
	rsc_reset_source_capture #(.POR_CYCLES(24'd50), .MCD_CYCLES(24'd20)) u_rsc_reset_source_capture (.clk(clk),
		.srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wdtTimeout(wdt), .watchedClkToggle(tog), .supplyLow(supLow),
		.supplyMonitorEnablePin(supply_monitor_enable_pin), .convertStartInputN(cnvN), .comparatorOutN(cmpN), .rstPinIn(pinIn),
		.rstPinOut(pinOut), .rstPinOeN(pinOeN), .sysReset(sysRst), .irq(irq));
	rsc_pin_partner u_rsc_pin_partner (.rstPinOut(pinOut), .rstPinOeN(pinOeN), .pullLow(pullLow), .rstPinIn(pinIn));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (togRun) begin
			tog <= ~tog;
		end
	end
	function [31:0] xs(input [31:0] s);
		begin
			s = s ^ (s << 13);
			s = s ^ (s >> 17);
			xs = s ^ (s << 5);
		end
	endfunction
	// Order: software, watchdog, pin, missing clock, forced power-on, comparator, convert, supply
	function [7:0] expCause(input integer c);
		expCause = 64'h0240200204010810 >> (c * 8);
	endfunction
	task chk(input string name, input [7:0] e, input [7:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("BAD %0s expected %h seen %h", name, e, g);
			end
		end
	endtask
	task bus(input [3:0] a, input w, input [7:0] d);
		begin
			@(posedge clk);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= {24'h0, d};
			@(posedge clk);
			while (ack !== 1'b1) begin
				@(posedge clk);
			end
			q = rdat[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task end_sim;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// Sources stay active a random while after entry: events during reset must be ignored
	task waitRst;
		begin
			n = 0;
			drv = 1'b0;
			while (sysRst !== 1'b1 && n < 200) begin
				@(posedge clk);
				n = n + 1;
				drv = drv | (pinOeN === 1'b0);
			end
			seed = xs(seed);
			repeat (seed[2:0]) @(posedge clk);
			wdt <= 1'b0;
			supLow <= 1'b0;
			cmpN <= 1'b1;
			cnvN <= 1'b1;
			pullLow <= 1'b0;
			togRun <= 1'b1;
			while (sysRst !== 1'b0 && n < 2000) begin
				@(posedge clk);
				n = n + 1;
				drv = drv | (pinOeN === 1'b0);
			end
			chk("reset done", 8'h00, {7'h0, n >= 2000});
		end
	endtask
	task fire(input integer c);
		begin
			case (c)
				0: bus(4'h0, 1'b1, 8'h10);
				1: wdt <= 1'b1;
				2: pullLow <= 1'b1;
				3: begin
					bus(4'h0, 1'b1, 8'h04);
					bus(4'hC, 1'b0, 8'h00);
					chk("detector enable", 8'h01, q & 8'h01);
					togRun <= 1'b0;
				end
				4: bus(4'h0, 1'b1, 8'h01);
				5: begin
					bus(4'h0, 1'b1, 8'h20);
					cmpN <= 1'b0;
				end
				6: begin
					bus(4'h0, 1'b1, 8'h40);
					cnvN <= 1'b0;
				end
				default: begin
					bus(4'h0, 1'b1, 8'h00);
					bus(4'hC, 1'b0, 8'h00);
					chk("supply select", 8'h00, q & 8'h02);
					bus(4'h0, 1'b1, 8'h02);
					supLow <= 1'b1;
				end
			endcase
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		waitRst;
		bus(4'h0, 1'b0, 8'h00);
		chk("cause", 8'h02, q);
		bus(4'h4, 1'b0, 8'h00);
		chk("status", 8'h02, q);
		repeat (3) @(posedge clk);
		chk("irq masked", 8'h00, {7'h0, irq});
		bus(4'h2, 1'b0, 8'h00);
		chk("unmapped", 8'h00, q);
		bus(4'h8, 1'b1, 8'h7F);
		// Monitor pin low: a selected monitor must not reset on a low supply
		supply_monitor_enable_pin <= 1'b0;
		repeat (4) @(posedge clk);
		bus(4'hC, 1'b0, 8'h00);
		chk("monitor pin", 8'h00, q & 8'h20);
		bus(4'h0, 1'b1, 8'h02);
		supLow <= 1'b1;
		repeat (10) @(posedge clk);
		chk("monitor off", 8'h00, {7'h0, sysRst});
		supLow <= 1'b0;
		repeat (4) @(posedge clk);
		supply_monitor_enable_pin <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 16; i = i + 1) begin
			seed = xs(seed);
			k = (i < 8) ? i : seed[2:0];
			fire(k);
			waitRst;
			bus(4'h0, 1'b0, 8'h00);
			chk("cause", expCause(k), q);
			chk("pin drive", {7'h0, k == 4 || k == 7}, {7'h0, drv});
			repeat (3) @(posedge clk);
			chk("irq set", 8'h01, {7'h0, irq});
			bus(4'h4, 1'b1, 8'h7F);
			repeat (3) @(posedge clk);
			chk("irq cleared", 8'h00, {7'h0, irq});
			$display("test %0d cause %h done", i, expCause(k));
		end
		end_sim;
	end
	// Sixteen resets of at most a few hundred cycles each fit well inside 20000 cycles
	initial begin
		#400000;
		fails = fails + 1;
		$display("BAD run time expected end seen hang");
		end_sim;
	end
endmodule

// ---- rsc_sync2.v ----
// Two flip-flop synchroniser, one lane per input bit.
// Assumes each input is a slow level from outside the clk domain.
`timescale 1ns/1ps

module rsc_sync2 #(
	parameter WIDTH = 6
) (
	input wire clk,
	input wire srst,
	input wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);

	// ****************************************
	// Per-bit synchroniser lanes
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
			reg meta_reg;
			reg stable_reg;
			// Reset to high: every watched input but the clock toggle idles high
			always @(posedge clk) begin
				if (srst) begin
					meta_reg <= 1'b1;
					stable_reg <= 1'b1;
				end else begin
					meta_reg <= din[i];
					stable_reg <= meta_reg;
				end
			end
			assign dout[i] = stable_reg;
		end
	endgenerate

endmodule
